// ==== inc/ddr2_ext_pkg.sv ====
// constants, field layouts and carrier types for the extended mode block
package ddr2_ext_pkg;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 16;
  localparam int STEP_W = 4;
  localparam int CNT_W = 8;

  // bank select codes of the extended mode register writes
  localparam logic [1:0] BA_EMR1 = 2'h1;
  localparam logic [1:0] BA_EMR2 = 2'h2;
  localparam logic [1:0] BA_EMR3 = 2'h3;

  // field positions inside the address word of an EMR(1) write
  localparam int F_RTT_LO = 2;
  localparam int F_RTT_HI = 6;
  localparam int F_AL_LSB = 3;
  localparam int F_OCD_LSB = 7;
  localparam int F_DQSN_DIS = 10;
  // extended self-refresh rate bit of EMR(2)
  localparam int F_SRT = 7;

  // calibration control field codes, A9 A8 A7
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DRV1 = 3'h1;
  localparam logic [2:0] OCD_DRV0 = 3'h2;
  localparam logic [2:0] OCD_ADJ = 3'h4;
  localparam logic [2:0] OCD_DFLT = 3'h7;

  // adjust codes packed as {beat0, beat1, beat2, beat3}
  localparam logic [3:0] ADJ_NOP = 4'h0;
  localparam logic [3:0] ADJ_PU_UP = 4'h1;
  localparam logic [3:0] ADJ_PU_DN = 4'h2;
  localparam logic [3:0] ADJ_PD_UP = 4'h4;
  localparam logic [3:0] ADJ_PD_DN = 4'h8;
  localparam logic [3:0] ADJ_BOTH_UP = 4'h5;
  localparam logic [3:0] ADJ_PU_DN_PD_UP = 4'h6;
  localparam logic [3:0] ADJ_PU_UP_PD_DN = 4'h9;
  localparam logic [3:0] ADJ_BOTH_DN = 4'hA;

  // strength range and the step taken by the default setting
  localparam logic [STEP_W-1:0] STEP_MIN = 4'h0;
  localparam logic [STEP_W-1:0] STEP_MAX = 4'hF;
  localparam logic [STEP_W-1:0] STEP_DEFAULT = 4'h8;

  // reset values
  localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;
  localparam logic [1:0] RTT_RESET = 2'h0;
  localparam logic [2:0] AL_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // timing, figures in ns, counts in link clock cycles
  localparam int LINK_PERIOD_NS = 12;
  localparam int T_OIT_NS = 12;
  localparam int T_MOD_MIN_NS = 0;
  localparam int OIT_RAW = (T_OIT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int OIT_CYC = (OIT_RAW < 1) ? 1 : OIT_RAW;
  localparam int MOD_RAW = (T_MOD_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int MOD_CYC = (MOD_RAW < 1) ? 1 : MOD_RAW;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_DRIVE = 2'b01,
    MODE_ADJUST = 2'b10
  } ocd_mode_e;

  typedef enum logic [1:0] {
    ADJ_WAIT = 2'b00,
    ADJ_SECOND = 2'b01,
    ADJ_DONE = 2'b10
  } adj_phase_e;

  // command and address pins as sampled on the link clock
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } ddr_cmd_s;

  // state shown to the core clock domain
  typedef struct packed {
    logic [STEP_W-1:0] pu_step;
    logic [STEP_W-1:0] pd_step;
    logic srt_en;
    logic [1:0] ocd_mode;
  } link_status_s;
endpackage

// ==== logic/ddr2_ext_ctrl.sv ====
// extended mode registers, driver calibration and termination control
`timescale 1ns/100ps
`default_nettype none

// Contract
// - EMR2 write is all command strobes low with BA0 low, BA1 high.
// - EMR3 write is all command strobes low with both bank bits high.
// - EMR1 A9..A7 selects exit, drive high, drive low, adjust, default.
// - drive high sets DQ, DQS high, DQS# low; drive low inverts.
// - four-beat adjust codes step pull-up and pull-down strengths.
// - strengths span 16 steps and saturate at the range limits.
// - adjust code is captured at write latency AL plus CL minus one.
// - adjust beats are taken in fixed order beat 0 to beat 3.
// - drivers turn on tOIT after drive entry, off tOIT after exit.
// - one strength setting drives every DQ and strobe output.
// - ODT pin gates termination; DQS# terminated only when A10 zero.
// - termination is forced off during self refresh.
// - new termination value takes effect inside the tMOD window.
// - EMR1 fields: A2/A6 Rtt, A10 DQS# off, A5..A3 AL, A9..A7 OCD.
module ddr2_ext_ctrl
  import ddr2_ext_pkg::*;
(
  // core clock domain
  input wire logic core_clk_i,
  input wire logic rst_i,
  // link clock domain, command and data pins
  input wire logic dram_clk_i,
  input wire logic cke_i,
  input wire ddr_cmd_s cmd_i,
  input wire logic [DQ_W-1:0] dq_rise_i,
  input wire logic [DQ_W-1:0] dq_fall_i,
  input wire logic odt_i,
  // link clock domain, settings from the rest of the device
  input wire logic [2:0] cas_lat_i,
  input wire logic self_refresh_i,
  // link clock domain, calibration drive outputs
  output logic [DQ_W-1:0] dq_o,
  output logic dqs_o,
  output logic dqs_n_o,
  output logic drv_oe_o,
  output logic [STEP_W-1:0] pu_step_o,
  output logic [STEP_W-1:0] pd_step_o,
  // link clock domain, termination and register fields
  output logic term_en_o,
  output logic term_dqs_n_o,
  output logic [1:0] rtt_sel_o,
  output logic [2:0] add_lat_o,
  output logic srt_en_o,
  output logic [ADDR_W-1:0] emr3_o,
  // core clock domain status copy
  output link_status_s status_o
);

  // one saturating step, a move past either end is dropped
  function automatic logic [STEP_W-1:0] step(input logic [STEP_W-1:0] v,
                                             input logic up,
                                             input logic dn);
    logic [STEP_W-1:0] r;
    r = v;
    if (up && v != STEP_MAX) begin
      r = v + 4'h1;
    end else if (dn && v != STEP_MIN) begin
      r = v - 4'h1;
    end
    return r;
  endfunction

  // adjust code to {pu_up, pu_dn, pd_up, pd_dn}
  function automatic logic [3:0] decode_adj(input logic [3:0] code);
    logic [3:0] r;
    r = 4'h0;
    case (code)
      ADJ_NOP: r = 4'h0;
      ADJ_PU_UP: r = 4'h8;
      ADJ_PU_DN: r = 4'h4;
      ADJ_PD_UP: r = 4'h2;
      ADJ_PD_DN: r = 4'h1;
      ADJ_BOTH_UP: r = 4'hA;
      ADJ_PU_DN_PD_UP: r = 4'h6;
      ADJ_PU_UP_PD_DN: r = 4'h9;
      ADJ_BOTH_DN: r = 4'h5;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // reset brought into the link domain through two flops
  logic lrst_meta;
  logic lrst;
  always_ff @(posedge dram_clk_i) begin
    lrst_meta <= rst_i;
    lrst <= lrst_meta;
  end

  // link state
  logic [ADDR_W-1:0] emr2, next_emr2;
  logic [ADDR_W-1:0] emr3, next_emr3;
  logic [1:0] rtt_pend, next_rtt_pend;
  logic [1:0] rtt_act, next_rtt_act;
  logic dqsn_dis, next_dqsn_dis;
  logic [2:0] al, next_al;
  logic mod_busy, next_mod_busy;
  logic [CNT_W-1:0] mod_cnt, next_mod_cnt;
  ocd_mode_e mode, next_mode;
  logic drv_high, next_drv_high;
  logic dqs_n, next_dqs_n;
  logic oe_target, next_oe_target;
  logic oe, next_oe;
  logic [CNT_W-1:0] oit_cnt, next_oit_cnt;
  adj_phase_e phase, next_phase;
  logic [CNT_W-1:0] adj_cnt, next_adj_cnt;
  logic [1:0] beat_hi, next_beat_hi;
  logic [STEP_W-1:0] pu, next_pu;
  logic [STEP_W-1:0] pd, next_pd;
  logic term_en, next_term_en;
  logic term_dqs_n, next_term_dqs_n;
  // handshake toward the core domain
  link_status_s stat_hold, next_stat_hold;
  link_status_s stat_now;
  logic req, next_req;
  logic ack_meta;
  logic ack_sync;
  logic ack;

  logic emrs;
  logic [2:0] ocd_code;
  logic [3:0] wl;
  logic [3:0] moves;

  // link next state: command decode, calibration, termination
  always_comb begin
    next_emr2 = emr2;
    next_emr3 = emr3;
    next_rtt_pend = rtt_pend;
    next_rtt_act = rtt_act;
    next_dqsn_dis = dqsn_dis;
    next_al = al;
    next_mod_busy = mod_busy;
    next_mod_cnt = mod_cnt;
    next_mode = mode;
    next_drv_high = drv_high;
    next_oe_target = oe_target;
    next_oe = oe;
    next_oit_cnt = oit_cnt;
    next_phase = phase;
    next_adj_cnt = adj_cnt;
    next_beat_hi = beat_hi;
    next_pu = pu;
    next_pd = pd;
    moves = 4'h0;
    // a mode register write class command, only while cke is high
    emrs = cke_i && !cmd_i.cs_n && !cmd_i.ras_n && !cmd_i.cas_n &&
           !cmd_i.we_n;
    ocd_code = cmd_i.addr[F_OCD_LSB+2:F_OCD_LSB];
    wl = {1'b0, cmd_i.addr[F_AL_LSB+2:F_AL_LSB]} + {1'b0, cas_lat_i}
         - 4'h1;

    // tMOD window: pending termination value lands at its minimum
    if (mod_busy) begin
      if (mod_cnt <= CNT_ONE) begin
        next_rtt_act = rtt_pend;
        next_mod_busy = 1'b0;
      end else begin
        next_mod_cnt = mod_cnt - CNT_ONE;
      end
    end

    // adjust code capture, two beats per link clock edge pair
    if (mode == MODE_ADJUST) begin
      case (phase)
        ADJ_WAIT: begin
          if (adj_cnt == CNT_ZERO) begin
            next_beat_hi = {dq_rise_i[0], dq_fall_i[0]};
            next_phase = ADJ_SECOND;
          end else begin
            next_adj_cnt = adj_cnt - CNT_ONE;
          end
        end
        ADJ_SECOND: begin
          moves = decode_adj({beat_hi, dq_rise_i[0], dq_fall_i[0]});
          next_pu = step(pu, moves[3], moves[2]);
          next_pd = step(pd, moves[1], moves[0]);
          next_phase = ADJ_DONE;
        end
        ADJ_DONE: next_phase = ADJ_DONE;
        default: next_phase = ADJ_DONE;
      endcase
    end

    // register writes
    if (emrs && cmd_i.ba == BA_EMR2) begin
      next_emr2 = cmd_i.addr;
    end
    if (emrs && cmd_i.ba == BA_EMR3) begin
      next_emr3 = cmd_i.addr;
    end
    if (emrs && cmd_i.ba == BA_EMR1) begin
      next_dqsn_dis = cmd_i.addr[F_DQSN_DIS];
      next_al = cmd_i.addr[F_AL_LSB+2:F_AL_LSB];
      next_rtt_pend = {cmd_i.addr[F_RTT_HI], cmd_i.addr[F_RTT_LO]};
      next_mod_busy = 1'b1;
      next_mod_cnt = CNT_W'(MOD_CYC);
      case (ocd_code)
        OCD_EXIT: begin
          // exit also ends the drive; drivers drop after tOIT
          next_mode = MODE_IDLE;
          next_oe_target = 1'b0;
        end
        OCD_DRV1: begin
          next_mode = MODE_DRIVE;
          next_drv_high = 1'b1;
          next_oe_target = 1'b1;
        end
        OCD_DRV0: begin
          next_mode = MODE_DRIVE;
          next_drv_high = 1'b0;
          next_oe_target = 1'b1;
        end
        OCD_ADJ: begin
          next_mode = MODE_ADJUST;
          next_phase = ADJ_WAIT;
          // wl is at least one for any legal CAS latency
          next_adj_cnt = {4'h0, wl} - CNT_ONE;
        end
        OCD_DFLT: begin
          next_pu = STEP_DEFAULT;
          next_pd = STEP_DEFAULT;
        end
        default: next_mode = mode; // undefined codes leave mode, drive and strengths alone
      endcase
    end

    // output enable follows its target after tOIT
    if (next_oe_target != oe_target) begin
      next_oit_cnt = CNT_W'(OIT_CYC);
    end else if (oe != oe_target) begin
      if (oit_cnt <= CNT_ONE) begin
        next_oe = oe_target;
      end else begin
        next_oit_cnt = oit_cnt - CNT_ONE;
      end
    end

    // complement strobe kept in its own flop so the pin has no inverter
    next_dqs_n = ~next_drv_high;

    // termination follows the pin, never during self refresh
    next_term_en = odt_i && !self_refresh_i;
    next_term_dqs_n = odt_i && !self_refresh_i && !dqsn_dis;

    // status snapshot, reloaded once the core has taken the last one
    stat_now = '{pu_step: pu, pd_step: pd, srt_en: emr2[F_SRT],
                 ocd_mode: mode};
    next_stat_hold = stat_hold;
    next_req = req;
    if (ack_sync == req && stat_now != stat_hold) begin
      next_stat_hold = stat_now;
      next_req = ~req;
    end
  end

  // link registers
  always_ff @(posedge dram_clk_i) begin
    if (lrst) begin
      emr2 <= EMR_RESET;
      emr3 <= EMR_RESET;
      rtt_pend <= RTT_RESET;
      rtt_act <= RTT_RESET;
      dqsn_dis <= 1'b0;
      al <= AL_RESET;
      mod_busy <= 1'b0;
      mod_cnt <= CNT_ZERO;
      mode <= MODE_IDLE;
      drv_high <= 1'b0;
      dqs_n <= 1'b1;
      oe_target <= 1'b0;
      oe <= 1'b0;
      oit_cnt <= CNT_ZERO;
      phase <= ADJ_DONE;
      adj_cnt <= CNT_ZERO;
      beat_hi <= 2'h0;
      pu <= STEP_DEFAULT;
      pd <= STEP_DEFAULT;
      term_en <= 1'b0;
      term_dqs_n <= 1'b0;
      stat_hold <= '0;
      req <= 1'b0;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      emr2 <= next_emr2;
      emr3 <= next_emr3;
      rtt_pend <= next_rtt_pend;
      rtt_act <= next_rtt_act;
      dqsn_dis <= next_dqsn_dis;
      al <= next_al;
      mod_busy <= next_mod_busy;
      mod_cnt <= next_mod_cnt;
      mode <= next_mode;
      drv_high <= next_drv_high;
      dqs_n <= next_dqs_n;
      oe_target <= next_oe_target;
      oe <= next_oe;
      oit_cnt <= next_oit_cnt;
      phase <= next_phase;
      adj_cnt <= next_adj_cnt;
      beat_hi <= next_beat_hi;
      pu <= next_pu;
      pd <= next_pd;
      term_en <= next_term_en;
      term_dqs_n <= next_term_dqs_n;
      stat_hold <= next_stat_hold;
      req <= next_req;
      ack_meta <= ack;
      ack_sync <= ack_meta;
    end
  end

  // link outputs, all straight from flops
  assign dq_o = {DQ_W{drv_high}};
  assign dqs_o = drv_high;
  assign dqs_n_o = dqs_n;
  assign drv_oe_o = oe;
  assign pu_step_o = pu;
  assign pd_step_o = pd;
  assign term_en_o = term_en;
  assign term_dqs_n_o = term_dqs_n;
  assign rtt_sel_o = rtt_act;
  assign add_lat_o = al;
  assign srt_en_o = emr2[F_SRT];
  assign emr3_o = emr3;

  // core side of the handshake; stat_hold is stable while req differs
  logic req_meta;
  logic req_sync;
  logic next_ack;
  link_status_s next_status;
  always_comb begin
    next_ack = ack;
    next_status = status_o;
    if (req_sync != ack) begin
      next_status = stat_hold;
      next_ack = req_sync;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      ack <= 1'b0;
      status_o <= '0;
    end else begin
      req_meta <= req;
      req_sync <= req_meta;
      ack <= next_ack;
      status_o <= next_status;
    end
  end

endmodule

`default_nettype wire

// ==== test/ddr2_ext_ctrl_monitor.sv ====
// concurrent checks on the extended mode block pins
`timescale 1ns/100ps
`default_nettype none
module ddr2_ext_ctrl_monitor
  import ddr2_ext_pkg::*;
(
  // link clock, reset and pins
  input wire logic rst_i,
  input wire logic dram_clk_i,
  input wire logic cke_i,
  input wire ddr_cmd_s cmd_i,
  input wire logic self_refresh_i,
  // outputs under watch
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dqs_o,
  input wire logic dqs_n_o,
  input wire logic drv_oe_o,
  input wire logic [STEP_W-1:0] pu_step_o,
  input wire logic [STEP_W-1:0] pd_step_o,
  input wire logic term_en_o,
  input wire logic [1:0] rtt_sel_o,
  input wire logic srt_en_o,
  input wire logic [ADDR_W-1:0] emr3_o
);
  logic [3:0] up;
  logic wr, e1, drv;
  logic [2:0] ocd;
  logic [1:0] rtt;
  // link state leaves reset some edges after rst_i, so checks wait too
  always_ff @(posedge dram_clk_i) up <= rst_i ? 4'h0 : {up[2:0], 1'b1};
  // register write decode; bits 18:15 are the four command strobes
  assign wr = cke_i && cmd_i[18:15] == 4'h0;
  assign e1 = wr && cmd_i.ba == BA_EMR1;
  assign ocd = cmd_i.addr[F_OCD_LSB+:3];
  assign drv = e1 && (ocd == OCD_DRV1 || ocd == OCD_DRV0);
  assign rtt = {cmd_i.addr[F_RTT_HI], cmd_i.addr[F_RTT_LO]};
  default clocking @(posedge dram_clk_i); endclocking
  default disable iff (!up[3]);
  a_srt_store: assert property (
    wr && cmd_i.ba == BA_EMR2 |=> srt_en_o == $past(cmd_i.addr[F_SRT]))
    else $error("refresh rate bit not stored");
  a_emr3_store: assert property (
    wr && cmd_i.ba == BA_EMR3 |=> emr3_o == $past(cmd_i.addr))
    else $error("register 3 not stored");
  a_rtt_delay: assert property (
    e1 |-> ##2 rtt_sel_o == $past(rtt, 2))
    else $error("termination value not applied");
  a_drive_level: assert property (
    drv |=> dq_o == {DQ_W{$past(ocd[0])}} && dqs_o == $past(ocd[0])
      && dqs_n_o != dqs_o)
    else $error("drive levels wrong");
  a_oe_on: assert property (
    drv |-> ##1 !drv_oe_o ##1 drv_oe_o)
    else $error("drivers not on in time");
  a_oe_off: assert property (
    drv_oe_o && e1 && ocd == OCD_EXIT |=> drv_oe_o ##1 !drv_oe_o)
    else $error("drivers not off in time");
  a_dflt_step: assert property (
    e1 && ocd == OCD_DFLT |=> pu_step_o == STEP_DEFAULT
      && pd_step_o == STEP_DEFAULT)
    else $error("default strength not set");
  a_sref_term: assert property (
    self_refresh_i |=> !term_en_o)
    else $error("termination on in self refresh");
endmodule
`default_nettype wire

// ==== test/ddr2_ctrl_model.sv ====
// controller-side model: commands, adjust code bursts and the ODT pin
`timescale 1ns/100ps
`default_nettype none
module ddr2_ctrl_model
  import ddr2_ext_pkg::*;
(
  // link clock
  input wire logic dram_clk_i,
  // pins toward the device
  output logic cke_o,
  output var ddr_cmd_s cmd_o,
  output logic [DQ_W-1:0] dq_rise_o,
  output logic [DQ_W-1:0] dq_fall_o,
  output logic odt_o
);
  // idle pins: deselected, clock enabled, termination off
  initial begin
    cke_o = 1'b1;
    cmd_o = '1;
    dq_rise_o = 16'h0000;
    dq_fall_o = 16'h0000;
    odt_o = 1'b0;
  end
  // one register write; the idle cycle after it covers the write time
  task automatic emrs(input logic [1:0] ba, input logic [ADDR_W-1:0] a,
    input logic ck);
    @(posedge dram_clk_i);
    cke_o <= ck;
    cmd_o <= {4'h0, ba, a};
    @(posedge dram_clk_i);
    cke_o <= 1'b1;
    cmd_o <= ~cmd_o; // deselect, released lines show the inverse
  endtask
  // same code on every DQ, beats in fixed order, first pair at WL
  task automatic burst(input logic [3:0] code, input int wl);
    repeat (wl - 1) @(posedge dram_clk_i);
    dq_rise_o <= {DQ_W{code[3]}};
    dq_fall_o <= {DQ_W{code[2]}};
    @(posedge dram_clk_i);
    dq_rise_o <= {DQ_W{code[1]}};
    dq_fall_o <= {DQ_W{code[0]}};
    @(posedge dram_clk_i);
    dq_rise_o <= ~dq_rise_o;
    dq_fall_o <= ~dq_fall_o;
  endtask
  // termination pin level
  task automatic set_odt(input logic v);
    @(posedge dram_clk_i);
    odt_o <= v;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// testbench for the extended mode, calibration and termination block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ddr2_ext_pkg::*;
  logic core_clk_i = 1'b0;
  logic dram_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] cas_lat_i = 3'h3;
  logic self_refresh_i = 1'b0;
  logic cke_i, odt_i, dqs_o, dqs_n_o, drv_oe_o, b;
  logic term_en_o, term_dqs_n_o, srt_en_o;
  ddr_cmd_s cmd_i;
  logic [DQ_W-1:0] dq_rise_i, dq_fall_i, dq_o;
  logic [STEP_W-1:0] pu_step_o, pd_step_o, pu, pd, c;
  logic [1:0] rtt_sel_o;
  logic [2:0] add_lat_o;
  logic [ADDR_W-1:0] emr3_o;
  link_status_s status_o;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  logic [3:0] tbl [12] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9,
    4'hA, 4'h0, 4'h3, 4'hF, 4'h7};
  // link rising edges are offset so they never meet a core rising edge
  always #25 core_clk_i = ~core_clk_i;
  always #6 dram_clk_i = ~dram_clk_i;
  // device and controller model
  ddr2_ext_ctrl i_ddr2_ext_ctrl (.core_clk_i, .rst_i, .dram_clk_i, .cke_i,
    .cmd_i, .dq_rise_i, .dq_fall_i, .odt_i, .cas_lat_i, .self_refresh_i,
    .dq_o, .dqs_o, .dqs_n_o, .drv_oe_o, .pu_step_o, .pd_step_o, .term_en_o,
    .term_dqs_n_o, .rtt_sel_o, .add_lat_o, .srt_en_o, .emr3_o, .status_o);
  ddr2_ctrl_model i_ddr2_ctrl_model (.dram_clk_i, .cke_o(cke_i),
    .cmd_o(cmd_i), .dq_rise_o(dq_rise_i), .dq_fall_o(dq_fall_i),
    .odt_o(odt_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lw(input int n);
    repeat (n) @(posedge dram_clk_i);
    #1;
  endtask
  task automatic emrs(input logic [1:0] ba, input logic [ADDR_W-1:0] a,
    input logic ck = 1'b1);
    i_ddr2_ctrl_model.emrs(ba, a, ck);
  endtask
  task automatic sref(input logic v);
    @(posedge core_clk_i);
    self_refresh_i <= v;
  endtask
  // adjust keeping latency 3 and the termination field, then exit
  task automatic adj(input logic [3:0] code);
    emrs(BA_EMR1, {3'h0, OCD_ADJ, 7'h58});
    i_ddr2_ctrl_model.burst(code, 2 + int'(cas_lat_i));
    lw(2);
    emrs(BA_EMR1, 13'h0058);
  endtask
  // one step of a strength setting, held at the range ends
  function automatic logic [3:0] bump(input logic [3:0] s, input logic u,
    input logic d);
    if (u && s != STEP_MAX) return s + 4'h1;
    if (d && s != STEP_MIN) return s - 4'h1;
    return s;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    lw(6);
    emrs(BA_EMR2, 13'h0080);
    lw(1);
    chk(srt_en_o, 1'b1);
    repeat (10) @(posedge core_clk_i);
    chk(status_o.srt_en, 1'b1);
    emrs(2'h0, 13'h0032);
    emrs(BA_EMR2, 13'h0000, 1'b0);
    lw(1);
    chk(srt_en_o, 1'b1);
    emrs(BA_EMR2, 13'h0000);
    lw(1);
    chk(srt_en_o, 1'b0);
    emrs(BA_EMR3, 13'h1ABC);
    lw(1);
    chk(emr3_o, 13'h1ABC);
    emrs(BA_EMR3, 13'h0000);
    lw(1);
    chk(emr3_o, 13'h0000);
    // latency lands at once, the termination value a cycle later
    emrs(BA_EMR1, 13'h0058);
    #1;
    chk({add_lat_o, rtt_sel_o}, 5'h0C);
    lw(1);
    chk(rtt_sel_o, 2'h2);
    // termination follows the pin, never in self refresh
    i_ddr2_ctrl_model.set_odt(1'b1);
    lw(2);
    chk({term_en_o, term_dqs_n_o}, 2'h3);
    sref(1'b1);
    lw(3);
    chk({term_en_o, term_dqs_n_o}, 2'h0);
    sref(1'b0);
    i_ddr2_ctrl_model.set_odt(1'b0);
    emrs(BA_EMR1, 13'h0458);
    lw(3);
    i_ddr2_ctrl_model.set_odt(1'b1);
    lw(2);
    chk({term_en_o, term_dqs_n_o}, 2'h2);
    i_ddr2_ctrl_model.set_odt(1'b0);
    emrs(BA_EMR1, 13'h0058);
    // both drive levels, drivers switching one cycle late
    for (int v = 0; v < 2; v++) begin
      b = v[0];
      emrs(BA_EMR1, {3'h0, b ? OCD_DRV1 : OCD_DRV0, 7'h58});
      #1;
      chk({dq_o, dqs_o, dqs_n_o, drv_oe_o}, {{DQ_W{b}}, b, !b, 1'b0});
      lw(1);
      chk(drv_oe_o, 1'b1);
      emrs(BA_EMR1, 13'h0058);
      #1;
      chk(drv_oe_o, 1'b1);
      lw(1);
      chk(drv_oe_o, 1'b0);
    end
    // default strength, every adjust code, then both range ends
    emrs(BA_EMR1, {3'h0, OCD_DFLT, 7'h58});
    lw(1);
    chk({pu_step_o, pd_step_o}, {STEP_DEFAULT, STEP_DEFAULT});
    emrs(BA_EMR1, 13'h0058);
    pu = STEP_DEFAULT;
    pd = STEP_DEFAULT;
    for (int i = 0; i < 38; i++) begin
      if (i == 6) begin
        @(posedge core_clk_i);
        cas_lat_i <= 3'h4;
      end
      c = i < 12 ? tbl[i] : (i < 21 ? ADJ_BOTH_UP : ADJ_BOTH_DN);
      adj(c);
      pu = bump(pu, c inside {4'h1, 4'h5, 4'h9}, c inside {4'h2, 4'h6, 4'hA});
      pd = bump(pd, c inside {4'h4, 4'h5, 4'h6}, c inside {4'h8, 4'h9, 4'hA});
      chk({pu_step_o, pd_step_o}, {pu, pd});
    end
    // an undefined code leaves steps and drivers alone
    emrs(BA_EMR1, {3'h0, 3'h5, 7'h58});
    lw(2);
    chk({pu_step_o, pd_step_o, drv_oe_o}, {pu, pd, 1'b0});
    emrs(BA_EMR1, 13'h0058);
    // default from the range floor is a real change, seen at the core too
    emrs(BA_EMR1, {3'h0, OCD_DFLT, 7'h58});
    #1;
    chk({pu_step_o, pd_step_o}, {STEP_DEFAULT, STEP_DEFAULT});
    emrs(BA_EMR1, 13'h0058);
    repeat (10) @(posedge core_clk_i);
    chk(status_o, {STEP_DEFAULT, STEP_DEFAULT, 1'b0, 2'h0});
    tally_and_finish();
  end
endmodule
bind ddr2_ext_ctrl ddr2_ext_ctrl_monitor i_ddr2_ext_ctrl_monitor (.rst_i,
  .dram_clk_i, .cke_i, .cmd_i, .self_refresh_i, .dq_o, .dqs_o, .dqs_n_o,
  .drv_oe_o, .pu_step_o, .pd_step_o, .term_en_o, .rtt_sel_o, .srt_en_o,
  .emr3_o);
`default_nettype wire
